// file: rtl/temp_monitor_pkg.sv
// package for the two-channel temperature monitor register bank
// assumes an smbus byte engine outside that presents decoded commands
package temp_monitor_pkg;

	// ----------------------------------------
	// command codes
	// ----------------------------------------
	localparam logic [7:0] LOCAL_TEMP_READ_CMD = 8'h00;
	localparam logic [7:0] REMOTE_TEMP_READ_CMD = 8'h01;
	localparam logic [7:0] STATUS_READ_CMD = 8'h02;
	localparam logic [7:0] CONFIG_READ_CMD = 8'h03;
	localparam logic [7:0] RATE_READ_CMD = 8'h04;
	localparam logic [7:0] LOCAL_HIGH_READ_CMD = 8'h05;
	localparam logic [7:0] LOCAL_LOW_READ_CMD = 8'h06;
	localparam logic [7:0] REMOTE_HIGH_READ_CMD = 8'h07;
	localparam logic [7:0] REMOTE_LOW_READ_CMD = 8'h08;
	localparam logic [7:0] CONFIG_WRITE_CMD = 8'h09;
	localparam logic [7:0] RATE_WRITE_CMD = 8'h0a;
	localparam logic [7:0] LOCAL_HIGH_WRITE_CMD = 8'h0b;
	localparam logic [7:0] LOCAL_LOW_WRITE_CMD = 8'h0c;
	localparam logic [7:0] REMOTE_HIGH_WRITE_CMD = 8'h0d;
	localparam logic [7:0] REMOTE_LOW_WRITE_CMD = 8'h0e;
	localparam logic [7:0] SINGLE_CONVERSION_CMD = 8'h0f;

	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int CFG_MASK_BIT = 7;
	localparam int CFG_STANDBY_BIT = 6;
	localparam logic [7:0] CFG_USED_MASK = 8'hc0;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [7:0] RATE_RESET = 8'h02;
	localparam logic [7:0] RATE_MAX_CODE = 8'h07;
	localparam logic [7:0] HIGH_LIMIT_RESET = 8'h7f;
	localparam logic [7:0] LOW_LIMIT_RESET = 8'hc9;
	localparam logic [7:0] TEMP_RESET = 8'h00;
	localparam logic [7:0] OPEN_DIODE_TEMP = 8'h7f;
	localparam logic [6:0] ALERT_RESPONSE_ADDR = 7'h0c;
	localparam logic [6:0] SLAVE_ADDR_RESET = 7'h18;
	localparam logic [7:0] READ_INVALID = 8'hff;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int MCLK_HZ = 40_000_000;
	// slowest interval is 16 s at code 00h; each code halves it
	localparam int BASE_PERIOD_S = 16;
	localparam longint BASE_PERIOD_CYCLES = longint'(MCLK_HZ) * BASE_PERIOD_S;
	localparam int CONV_TIME_MS = 170;
	localparam int CONV_CYCLES = (MCLK_HZ / 1000) * CONV_TIME_MS;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] local_temp;
		logic [7:0] remote_temp;
		logic remote_open;
	} measure_s;

	typedef struct packed {
		logic wr;
		logic rd;
		logic send;
		logic [7:0] cmd;
		logic [7:0] data;
	} host_req_s;

endpackage : temp_monitor_pkg

// file: rtl/temp_monitor_regs_alert.sv
// register bank, conversion scheduler and latched alert of the monitor
// assumes a byte-level smbus engine on the link clock that decodes
// write-byte, read-byte, send-byte and alert-response reads into pulses
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - config bit 7 set keeps alarm events off the alert line
// - config bit 6 set means software standby; bits 5..0 reserved
// - reset clears alert mask and software standby bits
// - results are eight-bit two's complement, one count per degree, msb first
// - result registers are read-only, loaded at every conversion end
// - rate register decodes three bits: 0.0625 Hz doubling to 8 Hz; at the default 170 ms conversion code 07h gives about 5.9 Hz
// - rate register resets to 02h and reads back
// - each result compared against its limits; reaching one sets flag and alert
// - limits reset to 7fh high and c9h low, all writable and readable
// - send-byte command 0fh starts a conversion immediately
// - one-shot during a running conversion is discarded
// - in software standby one-shot runs one cycle then returns to standby
// - in hardware standby one-shot starts nothing
// - status bits 7..2: busy, local hi, local lo, remote hi, remote lo, open
// - trip flags sticky until status read, unless cause persists; read-only
// - reset clears all trip flags; busy reads set, as a conversion starts at reset
// - every status condition except busy also raises alert
// - alert active low open drain, latched, not released by status read
// - alert response read returns own address in bits 7..1, bit 0 one
// - alert released after response read unless a fault persists
// - reads and writes use distinct command codes; mismatches are invalid
// - hardware standby inhibits and aborts conversions without updating results
module temp_monitor_regs_alert #(
	parameter longint BASE_CYCLES = temp_monitor_pkg::BASE_PERIOD_CYCLES,
	parameter int CONV_LEN = temp_monitor_pkg::CONV_CYCLES
) (
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_link_clk,
	input wire temp_monitor_pkg::host_req_s i_req,
	input wire logic i_ara_read,
	input wire logic [6:0] i_slave_addr,
	input wire logic i_hw_standby_n,
	input wire temp_monitor_pkg::measure_s i_measure,
	output logic [7:0] o_rdata,
	output logic o_alert_n_o,
	output logic o_alert_n_oe,
	output logic o_conv_active
);
	import temp_monitor_pkg::*;

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	logic rst_meta_q, rst_n_q;
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// link-domain reset, same two-stage release on the link clock
	logic lrst_meta_q, lrst_n_q;
	always_ff @(posedge i_link_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			lrst_meta_q <= 1'b0;
			lrst_n_q <= 1'b0;
		end
		else
		begin
			lrst_meta_q <= 1'b1;
			lrst_n_q <= lrst_meta_q;
		end
	end

	// ----------------------------------------
	// link domain: capture request, toggle across
	// ----------------------------------------
	// request words are held stable from the toggle until taken; the engine
	// must not post a new request faster than about six core clocks
	host_req_s lreq_q;
	logic lreq_tgl_q, lara_tgl_q;
	always_ff @(posedge i_link_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			lreq_q <= '0;
			lreq_tgl_q <= 1'b0;
			lara_tgl_q <= 1'b0;
		end
		else if (!lrst_n_q)
		begin
			lreq_tgl_q <= 1'b0;
			lara_tgl_q <= 1'b0;
		end
		else
		begin
			if (i_req.wr || i_req.rd || i_req.send)
			begin
				lreq_q <= i_req;
				lreq_tgl_q <= ~lreq_tgl_q;
			end
			if (i_ara_read)
				lara_tgl_q <= ~lara_tgl_q;
		end
	end

	// three-stage synchronisers; a toggle counts when stages two and three differ, standby is taken once they agree
	logic [2:0] req_sync_q, ara_sync_q, standby_sync_q;
	logic standby_q;
	always_ff @(posedge i_mclk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			req_sync_q <= '0;
			ara_sync_q <= '0;
			standby_sync_q <= 3'b111;
			standby_q <= 1'b0;
		end
		else
		begin
			req_sync_q <= {req_sync_q[1:0], lreq_tgl_q};
			ara_sync_q <= {ara_sync_q[1:0], lara_tgl_q};
			standby_sync_q <= {standby_sync_q[1:0], i_hw_standby_n};
			if (standby_sync_q[1] == standby_sync_q[2])
				standby_q <= ~standby_sync_q[2];
		end
	end
	wire logic req_evt = req_sync_q[1] ^ req_sync_q[2];
	wire logic ara_evt = ara_sync_q[1] ^ ara_sync_q[2];
	wire logic wr_evt = req_evt && lreq_q.wr;
	wire logic rd_evt = req_evt && lreq_q.rd;
	wire logic send_evt = req_evt && lreq_q.send;

	// ----------------------------------------
	// writable registers
	// ----------------------------------------
	logic [7:0] config_q, rate_q;
	logic [7:0] lhi_q, llo_q, rhi_q, rlo_q;
	always_ff @(posedge i_mclk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			config_q <= CONFIG_RESET;
			rate_q <= RATE_RESET;
			lhi_q <= HIGH_LIMIT_RESET;
			llo_q <= LOW_LIMIT_RESET;
			rhi_q <= HIGH_LIMIT_RESET;
			rlo_q <= LOW_LIMIT_RESET;
		end
		else if (wr_evt)
		begin
			case (lreq_q.cmd)
				CONFIG_WRITE_CMD: config_q <= lreq_q.data & CFG_USED_MASK;
				RATE_WRITE_CMD:
				begin
					if (lreq_q.data <= RATE_MAX_CODE)
						rate_q <= lreq_q.data;
				end
				LOCAL_HIGH_WRITE_CMD: lhi_q <= lreq_q.data;
				LOCAL_LOW_WRITE_CMD: llo_q <= lreq_q.data;
				REMOTE_HIGH_WRITE_CMD: rhi_q <= lreq_q.data;
				REMOTE_LOW_WRITE_CMD: rlo_q <= lreq_q.data;
				default: ;
			endcase
		end
	end
	wire logic alert_mask = config_q[CFG_MASK_BIT];
	wire logic sw_standby = config_q[CFG_STANDBY_BIT];

	// ----------------------------------------
	// conversion scheduler
	// ----------------------------------------
	typedef enum logic [1:0] {
		CONV_IDLE = 2'b01,
		CONV_RUN = 2'b10
	} conv_state_e;

	function automatic longint interval_of(input logic [2:0] code);
		interval_of = BASE_CYCLES >> code;
	endfunction : interval_of

	conv_state_e conv_q;
	longint wait_q;
	int run_q;
	logic conv_done;
	logic one_shot_pend;
	assign one_shot_pend = send_evt && (lreq_q.cmd == SINGLE_CONVERSION_CMD)
		&& (conv_q == CONV_IDLE) && !standby_q;
	assign conv_done = (conv_q == CONV_RUN) && (run_q >= CONV_LEN - 1) && !standby_q;

	always_ff @(posedge i_mclk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			conv_q <= CONV_RUN;
			wait_q <= '0;
			run_q <= 0;
		end
		else
		begin
			case (conv_q)
				CONV_IDLE:
				begin
					wait_q <= wait_q + 1;
					// software standby only runs on one-shot
					// idle plus run cycles add up to the larger of one interval and CONV_LEN + 1
					if (one_shot_pend || (!sw_standby && !standby_q
						&& wait_q >= interval_of(rate_q[2:0]) - CONV_LEN - 1))
					begin
						conv_q <= CONV_RUN;
						run_q <= 0;
					end
				end
				CONV_RUN:
				begin
					run_q <= run_q + 1;
					if (standby_q || conv_done)
					begin
						conv_q <= CONV_IDLE;
						wait_q <= '0;
					end
				end
				default: conv_q <= CONV_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// results, compare, status flags
	// ----------------------------------------
	logic [7:0] ltemp_q, rtemp_q;
	logic open_q;
	always_ff @(posedge i_mclk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			ltemp_q <= TEMP_RESET;
			rtemp_q <= TEMP_RESET;
			open_q <= 1'b0;
		end
		else if (conv_done)
		begin
			ltemp_q <= i_measure.local_temp;
			rtemp_q <= i_measure.remote_open ? OPEN_DIODE_TEMP : i_measure.remote_temp;
			open_q <= i_measure.remote_open;
		end
	end

	function automatic logic at_or_above(input logic [7:0] t, input logic [7:0] lim);
		at_or_above = $signed(t) >= $signed(lim);
	endfunction : at_or_above

	logic [4:0] cause;
	assign cause = {at_or_above(ltemp_q, lhi_q), at_or_above(llo_q, ltemp_q),
		at_or_above(rtemp_q, rhi_q) || open_q, at_or_above(rlo_q, rtemp_q), open_q};

	logic [4:0] flags_q;
	logic status_rd;
	assign status_rd = rd_evt && (lreq_q.cmd == STATUS_READ_CMD);
	logic conv_seen_q;
	always_ff @(posedge i_mclk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			flags_q <= '0;
			conv_seen_q <= 1'b0;
		end
		else
		begin
			conv_seen_q <= conv_seen_q | conv_done;
			// sticky, read clears unless cause remains; set wins
			if (status_rd)
				flags_q <= conv_seen_q ? cause : '0;
			else if (conv_seen_q)
				flags_q <= flags_q | cause;
		end
	end
	wire logic [4:0] fault_now = conv_seen_q ? cause : 5'h00;

	// ----------------------------------------
	// alert latch
	// ----------------------------------------
	logic alert_q;
	logic fault_rise;
	logic [4:0] fault_prev_q;
	assign fault_rise = |(fault_now & ~fault_prev_q) || (conv_done && |fault_now);
	always_ff @(posedge i_mclk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			alert_q <= 1'b0;
			fault_prev_q <= '0;
		end
		else
		begin
			fault_prev_q <= fault_now;
			if (fault_rise && !alert_mask)
				alert_q <= 1'b1;
			// response read releases unless fault remains
			else if (ara_evt && alert_q)
				alert_q <= |fault_now && !alert_mask;
		end
	end

	// ----------------------------------------
	// read data and pins
	// ----------------------------------------
	always_ff @(posedge i_mclk or negedge rst_n_q)
	begin
		if (!rst_n_q)
			o_rdata <= TEMP_RESET;
		else if (ara_evt)
			o_rdata <= {i_slave_addr, 1'b1};
		else if (rd_evt)
		begin
			case (lreq_q.cmd)
				LOCAL_TEMP_READ_CMD: o_rdata <= ltemp_q;
				REMOTE_TEMP_READ_CMD: o_rdata <= rtemp_q;
				STATUS_READ_CMD: o_rdata <= {conv_q == CONV_RUN, flags_q, 2'b00};
				CONFIG_READ_CMD: o_rdata <= config_q;
				RATE_READ_CMD: o_rdata <= rate_q;
				LOCAL_HIGH_READ_CMD: o_rdata <= lhi_q;
				LOCAL_LOW_READ_CMD: o_rdata <= llo_q;
				REMOTE_HIGH_READ_CMD: o_rdata <= rhi_q;
				REMOTE_LOW_READ_CMD: o_rdata <= rlo_q;
				default: o_rdata <= READ_INVALID;
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			o_alert_n_o <= 1'b0;
			o_alert_n_oe <= 1'b0;
			o_conv_active <= 1'b0;
		end
		else
		begin
			o_alert_n_o <= 1'b0;
			o_alert_n_oe <= alert_q;
			o_conv_active <= conv_q == CONV_RUN;
		end
	end

endmodule : temp_monitor_regs_alert

`default_nettype wire

// file: verification/tm_chk.sv
// port checker for the monitor register bank
// assumes it is bound onto temp_monitor_regs_alert
`timescale 1ns/1ps
`default_nettype none
module tm_chk #(
	parameter longint BASE_CYCLES = 4000,
	parameter int CONV_LEN = 100
) (
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_link_clk,
	input wire temp_monitor_pkg::host_req_s i_req,
	input wire logic i_ara_read,
	input wire logic [6:0] i_slave_addr,
	input wire logic i_hw_standby_n,
	input wire temp_monitor_pkg::measure_s i_measure,
	input wire logic [7:0] o_rdata,
	input wire logic o_alert_n_o,
	input wire logic o_alert_n_oe,
	input wire logic o_conv_active
);
	import temp_monitor_pkg::*;
	logic [7:0] ara_q;
	logic [15:0] busy_q;
	// ---
	// helpers: cycles since a response read, length of busy
	// ---
	always_ff @(posedge i_mclk or negedge i_resetn)
		if (!i_resetn)
			ara_q <= 8'hff;
		else if (i_ara_read)
			ara_q <= 8'h00;
		else if (ara_q != 8'hff)
			ara_q <= ara_q + 8'h01;
	always_ff @(posedge i_mclk or negedge i_resetn)
		if (!i_resetn)
			busy_q <= 16'h0000;
		else
			busy_q <= o_conv_active ? busy_q + 16'h0001 : 16'h0000;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);
	sequence s_rd(logic [7:0] c);
		i_req.rd && i_req.cmd == c;
	endsequence
	sequence s_rd_bad;
		i_req.rd && i_req.cmd inside {[CONFIG_WRITE_CMD:SINGLE_CONVERSION_CMD]};
	endsequence
	sequence s_ara_ans;
		##[1:64] o_rdata == {i_slave_addr, 1'b1};
	endsequence
	a_drain_low: assert property (o_alert_n_o == 1'b0)
		else $error("alert data not low");
	a_reset_quiet: assert property (disable iff (1'b0) !i_resetn |-> !o_alert_n_oe)
		else $error("alert active in reset");
	a_ara_answer: assert property ($rose(i_ara_read) |-> s_ara_ans)
		else $error("alert response byte wrong");
	a_alert_release: assert property ($fell(o_alert_n_oe) |-> ara_q < 8'd64)
		else $error("alert released without response read");
	a_bad_dir: assert property (s_rd_bad |-> ##[1:64] o_rdata == READ_INVALID)
		else $error("wrong-direction read not invalid");
	a_standby_idle: assert property (!i_hw_standby_n [*8] |-> !o_conv_active)
		else $error("conversion in hardware standby");
	a_busy_bound: assert property (busy_q <= CONV_LEN + 8)
		else $error("conversion overran");
	a_cfg_zero: assert property (s_rd(CONFIG_READ_CMD) |-> ##[1:64] o_rdata[5:0] == 6'h00)
		else $error("reserved config bits not zero");
	a_stat_zero: assert property (s_rd(STATUS_READ_CMD) |-> ##[1:64] o_rdata[1:0] == 2'h0)
		else $error("reserved status bits not zero");
endmodule : tm_chk
bind temp_monitor_regs_alert tm_chk #(.BASE_CYCLES(BASE_CYCLES), .CONV_LEN(CONV_LEN)) u_chk (
	.i_mclk(i_mclk), .i_resetn(i_resetn), .i_link_clk(i_link_clk), .i_req(i_req),
	.i_ara_read(i_ara_read), .i_slave_addr(i_slave_addr), .i_hw_standby_n(i_hw_standby_n),
	.i_measure(i_measure), .o_rdata(o_rdata), .o_alert_n_o(o_alert_n_o),
	.o_alert_n_oe(o_alert_n_oe), .o_conv_active(o_conv_active));
`default_nettype wire

// file: verification/tm_host.sv
// host controller model: one decoded request per call
// assumes the bank captures requests on the free-running link clock
`timescale 1ns/1ps
`default_nettype none
module tm_host (
	input wire logic i_link_clk,
	output var temp_monitor_pkg::host_req_s o_req,
	output var logic o_ara
);
	import temp_monitor_pkg::*;
	initial
	begin
		o_req = '0;
		o_ara = 1'b0;
	end
	// one pulse, direction code given by caller
	task automatic issue(input logic w, r, s, a, input logic [7:0] c, d);
		@(posedge i_link_clk);
		o_req <= '{w, r, s, c, d};
		o_ara <= a;
		@(posedge i_link_clk);
		// idle fields flip so a stale value never looks valid
		o_req <= '{1'b0, 1'b0, 1'b0, ~c, ~d};
		o_ara <= 1'b0;
		repeat (8) @(posedge i_link_clk);
	endtask : issue
endmodule : tm_host
`default_nettype wire

// file: verification/tb.sv
// self-checking bench for the monitor register bank
// assumes tm_host drives the link side and tm_chk is bound
`timescale 1ns/1ps
`default_nettype none
module tb;
	import temp_monitor_pkg::*;
	logic mclk = 1'b0;
	logic link_clk = 1'b1;
	logic resetn, standby_n, ara, al_o, al_oe, busy;
	logic [6:0] addr;
	logic [7:0] rdata, hi, lo, v;
	host_req_s req;
	measure_s meas;
	int error_cnt = 0;
	int n_compared = 0;
	`define CHK(n, e, g) check(n, e, g)
	always #12.5 mclk = ~mclk;
	always #80 link_clk = ~link_clk;
	tm_host host (.i_link_clk(link_clk), .o_req(req), .o_ara(ara));
	temp_monitor_regs_alert #(.BASE_CYCLES(4000), .CONV_LEN(100)) uut (
		.i_mclk(mclk), .i_resetn(resetn), .i_link_clk(link_clk), .i_req(req),
		.i_ara_read(ara), .i_slave_addr(addr), .i_hw_standby_n(standby_n),
		.i_measure(meas), .o_rdata(rdata), .o_alert_n_o(al_o),
		.o_alert_n_oe(al_oe), .o_conv_active(busy));
	task automatic stop_test();
		if (error_cnt == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test
	task automatic check(input string n, input logic [7:0] e, g);
		n_compared++;
		if (g !== e)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : check
	task automatic rd(input logic [7:0] c);
		host.issue(1'b0, 1'b1, 1'b0, 1'b0, c, 8'h00);
		v = rdata;
	endtask : rd
	task automatic wr(input logic [7:0] c, d);
		host.issue(1'b1, 1'b0, 1'b0, 1'b0, c, d);
	endtask : wr
	task automatic till(input logic lv);
		int k;
		for (k = 0; k < 2000 && busy !== lv; k++)
			@(posedge mclk);
		if (busy !== lv)
		begin
			`CHK("busy wait", 8'(lv), 8'(busy));
			stop_test();
		end
	endtask : till
	task automatic conv();
		till(1'b1);
		till(1'b0);
		till(1'b1);
		till(1'b0);
	endtask : conv
	function automatic measure_s trip(input int k);
		measure_s m;
		m = '0;
		case (k)
			0: m.local_temp = hi;
			1: m.local_temp = lo;
			2: m.remote_temp = hi + 8'h01;
			3: m.remote_temp = lo - 8'h01;
			default: m.remote_open = 1'b1;
		endcase
		return m;
	endfunction : trip
	initial
	begin
		logic [7:0] rv[6];
		int k;
		rv = '{8'h00, 8'h02, 8'h7f, 8'hc9, 8'h7f, 8'hc9};
		k = $urandom(2732);
		resetn = 1'b0;
		standby_n = 1'b1;
		addr = 7'($urandom);
		meas = '0;
		repeat (16) @(posedge mclk);
		resetn <= 1'b1;
		repeat (6) @(posedge link_clk);
		for (k = 0; k < 6; k++)
		begin
			rd(8'(3 + k));
			`CHK("reset value", rv[k], v);
		end
		rd(8'h02);
		`CHK("status at reset", 8'h00, v & 8'h7f);
		for (k = 0; k < 4; k++)
		begin
			hi = 8'($urandom);
			wr(8'(11 + k), hi);
			rd(8'(5 + k));
			`CHK("limit", hi, v);
		end
		hi = 8'($urandom_range(7));
		wr(8'h0a, hi);
		wr(8'h0a, 8'(8 + $urandom_range(247)));
		rd(8'h04);
		`CHK("rate", hi, v);
		wr(8'h09, 8'hff);
		rd(8'h03);
		`CHK("config", 8'hc0, v);
		wr(8'h09, 8'h00);
		wr(8'h0a, 8'h05);
		rd(8'h0c);
		`CHK("wrong direction", 8'hff, v);
		// conversion starts lie one rate interval apart, rise to rise
		till(1'b0);
		till(1'b1);
		for (k = 0; k < 2000 && busy === 1'b1; k++)
			@(posedge mclk);
		for (; k < 2000 && busy === 1'b0; k++)
			@(posedge mclk);
		`CHK("interval", 8'(4000 >> 5), 8'(k));
		hi = 8'($urandom_range(100, 20));
		lo = 8'(-$urandom_range(50, 10));
		for (k = 0; k < 4; k++)
			wr(8'(11 + k), k[0] ? lo : hi);
		// trips left by the random limits above must not leak into the flag checks
		rd(8'h02);
		// each fault kind: set, stick, clear, then the response read
		for (k = 0; k < 5; k++)
		begin
			@(posedge mclk);
			meas <= trip(k);
			conv();
			rd(8'h02);
			`CHK("trip flags", k == 4 ? 8'h14 : 8'h40 >> k, v & 8'h7c);
			`CHK("alert", 8'h01, 8'(al_oe));
			rd(8'h01);
			`CHK("remote temp", k == 4 ? 8'h7f : meas.remote_temp, v);
			rd(8'h00);
			`CHK("local temp", meas.local_temp, v);
			@(posedge mclk);
			meas <= '0;
			conv();
			rd(8'h02);
			`CHK("sticky flags", k == 4 ? 8'h14 : 8'h40 >> k, v & 8'h7c);
			rd(8'h02);
			`CHK("cleared flags", 8'h00, v & 8'h7c);
			`CHK("alert held", 8'h01, 8'(al_oe));
			host.issue(1'b0, 1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
			`CHK("alert response", {addr, 1'b1}, rdata);
			`CHK("alert released", 8'h00, 8'(al_oe));
		end
		wr(8'h09, 8'h80);
		@(posedge mclk);
		meas <= trip(0);
		conv();
		`CHK("masked alert", 8'h00, 8'(al_oe));
		@(posedge mclk);
		meas <= '0;
		conv();
		rd(8'h02);
		wr(8'h09, 8'h00);
		// one-shot during a conversion, then hardware standby aborts it and a second one-shot starts nothing
		till(1'b1);
		host.issue(1'b0, 1'b0, 1'b1, 1'b0, 8'h0f, 8'h00);
		@(posedge mclk);
		standby_n <= 1'b0;
		repeat (20) @(posedge mclk);
		host.issue(1'b0, 1'b0, 1'b1, 1'b0, 8'h0f, 8'h00);
		`CHK("hw standby busy", 8'h00, 8'(busy));
		@(posedge mclk);
		standby_n <= 1'b1;
		wr(8'h09, 8'h40);
		till(1'b0);
		repeat (300) @(posedge mclk);
		`CHK("sw standby idle", 8'h00, 8'(busy));
		host.issue(1'b0, 1'b0, 1'b1, 1'b0, 8'h0f, 8'h00);
		till(1'b1);
		till(1'b0);
		repeat (300) @(posedge mclk);
		`CHK("back to standby", 8'h00, 8'(busy));
		// a reset in mid-run must restore every writable register
		@(posedge mclk);
		resetn <= 1'b0;
		repeat (16) @(posedge mclk);
		resetn <= 1'b1;
		repeat (6) @(posedge link_clk);
		for (k = 0; k < 6; k++)
		begin
			rd(8'(3 + k));
			`CHK("reset again", rv[k], v);
		end
		stop_test();
	end
endmodule : tb
`default_nettype wire
